// file: rtl/srbr_pkg.sv
// Constants, register map and state codes for the read and buffer readback interpreter
package srbr_pkg;
	// Command opcodes handled here
	localparam logic [7:0]  OP_READ6        = 8'h08;
	localparam logic [7:0]  OP_READ10       = 8'h28;
	localparam logic [7:0]  OP_RDBUF        = 8'h3C;
	// Index of the last byte of each command block
	localparam logic [3:0]  CDB6_LAST       = 4'h5;
	localparam logic [3:0]  CDB10_LAST      = 4'h9;
	// Field positions inside command byte 1
	localparam int          REL_BIT         = 0;
	localparam int          FUA_BIT         = 3;
	localparam int          LUN_LSB         = 5;
	// Supported buffer readback modes
	localparam logic [2:0]  MODE_DATA       = 3'h0;
	localparam logic [2:0]  MODE_HDR        = 3'h3;
	// Sense keys reported on completion
	localparam logic [3:0]  SK_NONE         = 4'h0;
	localparam logic [3:0]  SK_ILLEGAL      = 4'h5;
	localparam logic [3:0]  SK_MISCOMPARE   = 4'hE;
	// Short read zero count stands for this many blocks
	localparam logic [16:0] READ6_ZERO_CNT  = 17'h00100;
	// Readback header length and largest available length
	localparam logic [23:0] HDR_LEN         = 24'h000004;
	localparam logic [18:0] AVAIL_MAX       = 19'h40000;
	// Register byte offsets
	localparam logic [3:0]  REG_AVAIL       = 4'h0;
	localparam logic [3:0]  REG_CTRL        = 4'h4;
	localparam logic [3:0]  REG_STATUS      = 4'h8;
	localparam logic [3:0]  REG_LAST_LBA    = 4'hC;
	// Register field positions
	localparam int          CTRL_CACHE_BIT  = 0;
	localparam int          STAT_BUSY_BIT   = 0;
	localparam int          STAT_INTERV_BIT = 1;
	localparam int          STAT_LBAV_BIT   = 2;
	localparam int          STAT_SENSE_LSB  = 4;
	// Reset values
	localparam logic [18:0] AVAIL_RST       = 19'h00000;
	localparam logic        CACHE_RST       = 1'b1;
	localparam logic        INTERV_RST      = 1'b1;
	// Controller states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CDB  = 4'h2,
		ST_EXEC = 4'h4,
		ST_SEND = 4'h8
	} srbr_state_t;
endpackage : srbr_pkg

// file: rtl/srbr_core.sv
// Read command decoder and buffer readback engine of the disk target
//
// Notes on behaviour
// - Accept six-byte 08H and ten-byte 28H reads
// - Short block: address bytes 1-3, count byte 4
// - Long block: address bytes 2-5, count 7-8
// - Transfer starts at the addressed logical block
// - Forced access bit set means read from media
// - Relative flag adds signed offset to last block
// - Relative clear means absolute first block
// - Short read zero count means 256 blocks
// - Long read zero count: no seek, success
// - Each block returns its latest written data
// - Readback 3CH alters nothing, sends header plus data
// - Mode 000b header plus data, 011b header only
// - Zero allocation length sends nothing, no error; code still reports miscompare when the intervening flag is set
// - Stop at allocation or available, whichever less
// - Header: reserved byte, three-byte available length
// - Empty buffer reports zero length, no data
// - Header length never reduced by truncation
// - Intervening command gives check condition, miscompare
// - Miscompare still delivers all requested bytes
`timescale 1ns/100ps
module srbr_core (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Command block byte stream
	input  wire logic        cdb_valid,
	input  wire logic        cdb_first,
	input  wire logic [7:0]  cdb_byte,
	// Command context from the controller
	input  wire logic        cmd_linked,
	input  wire logic        other_cmd,
	input  wire logic        wrbuf_done,
	// Read request towards the cache and media path
	output logic             rd_start,
	output logic      [31:0] rd_lba,
	output logic      [16:0] rd_count,
	output logic             rd_media,
	output logic      [2:0]  rd_unit,
	// Diagnostic buffer read port
	output logic      [17:0] buf_addr,
	input  wire logic [7:0]  buf_rdata,
	// Data-in byte stream to the bus
	output logic             din_valid,
	output logic      [7:0]  din_byte,
	input  wire logic        din_ready,
	// Command completion
	output logic             cmd_done,
	output logic             cmd_check,
	output logic      [3:0]  cmd_sense,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);

	// Packs four bytes most significant first
	function automatic logic [31:0] srbr_be32(input logic [7:0] b3, input logic [7:0] b2,
		input logic [7:0] b1, input logic [7:0] b0);
		return {b3, b2, b1, b0};
	endfunction : srbr_be32

	srbr_pkg::srbr_state_t state;        // Controller state
	srbr_pkg::srbr_state_t next_state;   // Next controller state
	logic [7:0]  cdb [0:9];              // Captured command block
	logic [3:0]  cdb_cnt;                // Next byte index
	logic [3:0]  cdb_last;               // Index of final byte
	logic        interv;                 // Command ran since last buffer write
	logic [31:0] last_lba;               // Last block accessed
	logic        lba_valid;              // Last block is meaningful
	logic        cache_allow;            // Software permits cache service
	logic [18:0] avail;                  // Bytes held in the diagnostic buffer
	logic [23:0] idx;                    // Next readback byte to load
	logic [23:0] xfer_n;                 // Readback bytes to send
	logic [18:0] hdr_avail;              // Available length frozen for header
	logic        miscmp;                 // Readback ends in miscompare

	// Decode of the captured block
	logic        is6, is10, isbuf, known_op, rel, rel_bad, mode_ok, buf_go, read_go;
	logic        exec_finish, load, send_end, first_op;
	logic [31:0] lba_field, start_lba, cnt10_w, alloc_w;
	logic [16:0] rd_len;
	logic [2:0]  mode;
	logic [23:0] total, xfer;
	logic [7:0]  next_byte;

	// Opcode classification
	assign is6      = (cdb[0] == srbr_pkg::OP_READ6);
	assign is10     = (cdb[0] == srbr_pkg::OP_READ10);
	assign isbuf    = (cdb[0] == srbr_pkg::OP_RDBUF);
	assign known_op = (cdb_byte == srbr_pkg::OP_READ6) || (cdb_byte == srbr_pkg::OP_READ10)
		|| (cdb_byte == srbr_pkg::OP_RDBUF);
	assign first_op = (state == srbr_pkg::ST_IDLE) && cdb_valid && cdb_first;

	// Address and count fields; short block uses only five address bits of byte 1
	assign lba_field = is6 ? srbr_be32(8'h00, {3'h0, cdb[1][4:0]}, cdb[2], cdb[3])
		: srbr_be32(cdb[2], cdb[3], cdb[4], cdb[5]);
	assign cnt10_w   = srbr_be32(8'h00, 8'h00, cdb[7], cdb[8]);
	assign rd_len    = is6 ? ((cdb[4] == 8'h00) ? srbr_pkg::READ6_ZERO_CNT
		: {9'h000, cdb[4]}) : {1'b0, cnt10_w[15:0]};

	// Relative addressing exists only in the long form; modular add handles negatives
	assign rel       = is10 && cdb[1][srbr_pkg::REL_BIT];
	assign start_lba = rel ? (last_lba + lba_field) : lba_field;
	// Without a linked command and a block accessed since reset there is nothing to offset from
	assign rel_bad   = rel && !(cmd_linked && lba_valid);
	assign read_go   = (is6 || is10) && !rel_bad && (rd_len != 17'h00000);

	// Readback decode
	assign mode      = cdb[1][2:0];
	assign mode_ok   = (mode == srbr_pkg::MODE_DATA) || (mode == srbr_pkg::MODE_HDR);
	assign alloc_w   = srbr_be32(8'h00, cdb[6], cdb[7], cdb[8]);
	assign total     = (mode == srbr_pkg::MODE_DATA)
		? srbr_pkg::HDR_LEN + {5'h00, avail} : srbr_pkg::HDR_LEN;
	assign xfer      = (alloc_w[23:0] < total) ? alloc_w[23:0] : total;
	assign buf_go    = isbuf && mode_ok && (xfer != 24'h000000);

	// Output stage may take a byte when empty or when its byte is being taken
	assign load      = (state == srbr_pkg::ST_SEND) && (!din_valid || din_ready)
		&& (idx != xfer_n);
	assign send_end  = (state == srbr_pkg::ST_SEND) && (!din_valid || din_ready)
		&& (idx == xfer_n);
	assign exec_finish = (state == srbr_pkg::ST_EXEC) && !buf_go;

	// Buffer is only read, never written, by this block
	assign buf_addr  = 18'(idx - srbr_pkg::HDR_LEN);

	// Header bytes first, then buffer bytes
	always_comb begin
		unique case (idx)
			24'h000000: next_byte = 8'h00;
			24'h000001: next_byte = {5'h00, hdr_avail[18:16]};
			24'h000002: next_byte = hdr_avail[15:8];
			24'h000003: next_byte = hdr_avail[7:0];
			default:    next_byte = buf_rdata;
		endcase
	end

	// Next-state logic
	always_comb begin
		next_state = state;
		unique case (state)
			srbr_pkg::ST_IDLE: begin
				if (first_op && known_op) begin
					next_state = srbr_pkg::ST_CDB;
				end
			end
			srbr_pkg::ST_CDB: begin
				if (cdb_valid && (cdb_cnt == cdb_last)) begin
					next_state = srbr_pkg::ST_EXEC;
				end
			end
			srbr_pkg::ST_EXEC: begin
				next_state = buf_go ? srbr_pkg::ST_SEND : srbr_pkg::ST_IDLE;
			end
			srbr_pkg::ST_SEND: begin
				if (send_end) begin
					next_state = srbr_pkg::ST_IDLE;
				end
			end
			default: next_state = srbr_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= srbr_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Command block capture; foreign opcodes are not collected
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 10; i++) begin
				cdb[i] <= 8'h00;
			end
			cdb_cnt  <= 4'h0;
			cdb_last <= 4'h0;
		end else if (first_op && known_op) begin
			cdb[0]   <= cdb_byte;
			cdb_cnt  <= 4'h1;
			cdb_last <= (cdb_byte == srbr_pkg::OP_READ6) ? srbr_pkg::CDB6_LAST
				: srbr_pkg::CDB10_LAST;
		end else if ((state == srbr_pkg::ST_CDB) && cdb_valid) begin
			cdb[cdb_cnt] <= cdb_byte;
			cdb_cnt      <= cdb_cnt + 4'h1;
		end
	end

	// Intervening-command flag; a new command in the same cycle as a buffer write wins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			interv <= srbr_pkg::INTERV_RST;
		end else if (other_cmd || (first_op && (cdb_byte != srbr_pkg::OP_RDBUF))) begin
			interv <= 1'b1;
		end else if (wrbuf_done) begin
			interv <= 1'b0;
		end
	end

	// Last block accessed, kept for relative addressing
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_lba  <= 32'h00000000;
			lba_valid <= 1'b0;
		end else if ((state == srbr_pkg::ST_EXEC) && read_go) begin
			last_lba  <= start_lba + {15'h0000, rd_len} - 32'h00000001;
			lba_valid <= 1'b1;
		end
	end

	// Read request; data integrity is owned by the cache and media path
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rd_start <= 1'b0;
			rd_lba   <= 32'h00000000;
			rd_count <= 17'h00000;
			rd_media <= 1'b0;
			rd_unit  <= 3'h0;
		end else begin
			rd_start <= (state == srbr_pkg::ST_EXEC) && read_go;
			if ((state == srbr_pkg::ST_EXEC) && read_go) begin
				rd_lba   <= start_lba;
				rd_count <= rd_len;
				// Forced access, or cache disabled by software, goes to media
				rd_media <= (is10 && cdb[1][srbr_pkg::FUA_BIT]) || !cache_allow;
				rd_unit  <= cdb[1][7:srbr_pkg::LUN_LSB];
			end
		end
	end

	// Readback setup; header length and miscompare are frozen at start
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			xfer_n    <= 24'h000000;
			hdr_avail <= 19'h00000;
			miscmp    <= 1'b0;
		end else if (state == srbr_pkg::ST_EXEC) begin
			xfer_n    <= buf_go ? xfer : 24'h000000;
			hdr_avail <= avail;
			miscmp    <= interv;
		end
	end

	// Byte output stage; miscompare does not cut the stream short
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			idx       <= 24'h000000;
			din_valid <= 1'b0;
			din_byte  <= 8'h00;
		end else if (state == srbr_pkg::ST_EXEC) begin
			idx       <= 24'h000000;
		end else if (load) begin
			din_byte  <= next_byte;
			din_valid <= 1'b1;
			idx       <= idx + 24'h000001;
		end else if (din_ready) begin
			din_valid <= 1'b0;
		end
	end

	// Completion status
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmd_done  <= 1'b0;
			cmd_check <= 1'b0;
			cmd_sense <= srbr_pkg::SK_NONE;
		end else begin
			cmd_done <= exec_finish || send_end;
			if (exec_finish && (rel_bad || (isbuf && !mode_ok))) begin
				cmd_check <= 1'b1;
				cmd_sense <= srbr_pkg::SK_ILLEGAL;
			end else if ((exec_finish && isbuf && interv) || (send_end && miscmp)) begin
				cmd_check <= 1'b1;
				cmd_sense <= srbr_pkg::SK_MISCOMPARE;
			end else if (exec_finish || send_end) begin
				cmd_check <= 1'b0;
				cmd_sense <= srbr_pkg::SK_NONE;
			end
		end
	end

	// Software registers; available length saturates at the buffer size
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			avail       <= srbr_pkg::AVAIL_RST;
			cache_allow <= srbr_pkg::CACHE_RST;
		end else if (reg_wr && (reg_addr == srbr_pkg::REG_AVAIL)) begin
			avail <= (reg_wdata > {13'h0000, srbr_pkg::AVAIL_MAX}) ? srbr_pkg::AVAIL_MAX
				: reg_wdata[18:0];
		end else if (reg_wr && (reg_addr == srbr_pkg::REG_CTRL)) begin
			cache_allow <= reg_wdata[srbr_pkg::CTRL_CACHE_BIT];
		end
	end

	// Read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= 32'h00000000;
			unique case (reg_addr)
				srbr_pkg::REG_AVAIL:    reg_rdata[18:0] <= avail;
				srbr_pkg::REG_CTRL:     reg_rdata[srbr_pkg::CTRL_CACHE_BIT] <= cache_allow;
				srbr_pkg::REG_STATUS: begin
					reg_rdata[srbr_pkg::STAT_BUSY_BIT]   <= (state != srbr_pkg::ST_IDLE);
					reg_rdata[srbr_pkg::STAT_INTERV_BIT] <= interv;
					reg_rdata[srbr_pkg::STAT_LBAV_BIT]   <= lba_valid;
					reg_rdata[srbr_pkg::STAT_SENSE_LSB +: 4] <= cmd_sense;
				end
				srbr_pkg::REG_LAST_LBA: reg_rdata <= last_lba;
				default:                reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// Checking helpers: bytes accepted and kind of the finishing command
	logic [23:0] sent_cnt;
	logic        was_buf;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sent_cnt <= 24'h000000;
			was_buf  <= 1'b0;
		end else if (state == srbr_pkg::ST_EXEC) begin
			sent_cnt <= 24'h000000;
			was_buf  <= isbuf;
		end else if (din_valid && din_ready) begin
			sent_cnt <= sent_cnt + 24'h000001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_short_zero_count: assert property ((state == srbr_pkg::ST_EXEC) && is6 &&
		(cdb[4] == 8'h00) |=> rd_start && (rd_count == 17'h00100))
		else $error("short read zero count not 256");
	chk_long_zero_count: assert property ((state == srbr_pkg::ST_EXEC) && is10 &&
		!rel_bad && (cnt10_w == 32'h0) |=> !rd_start && cmd_done && !cmd_check)
		else $error("long read zero count misbehaved");
	chk_relative_addr: assert property ((state == srbr_pkg::ST_EXEC) && rel &&
		read_go |=> rd_start && (rd_lba == $past(last_lba) + $past(lba_field)))
		else $error("relative start block wrong");
	chk_absolute_addr: assert property ((state == srbr_pkg::ST_EXEC) && is6
		|=> rd_lba == {11'h000, $past(cdb[1][4:0]), $past(cdb[2]), $past(cdb[3])})
		else $error("absolute start block wrong");
	chk_forced_media: assert property ((state == srbr_pkg::ST_EXEC) && read_go && is10 &&
		cdb[1][3] |=> rd_media)
		else $error("forced access not sent to media");
	chk_bad_mode: assert property ((state == srbr_pkg::ST_EXEC) && isbuf && !mode_ok
		|=> cmd_done && cmd_check && (cmd_sense == 4'h5) && !din_valid)
		else $error("unsupported mode not rejected");
	chk_zero_alloc: assert property ((state == srbr_pkg::ST_EXEC) && isbuf &&
		(alloc_w == 32'h0) |=> cmd_done ##1 !din_valid)
		else $error("zero allocation moved data");
	chk_sent_count: assert property (cmd_done && was_buf |-> sent_cnt == xfer_n)
		else $error("readback byte count wrong");
	chk_header_len: assert property (din_valid && (idx == 24'h000004) &&
		(state == srbr_pkg::ST_SEND) |-> din_byte == hdr_avail[7:0])
		else $error("header length byte wrong");
	chk_miscompare: assert property (cmd_done && was_buf && miscmp && $past(mode_ok)
		|-> cmd_check && (cmd_sense == 4'hE))
		else $error("miscompare not reported");
	chk_interv_clear: assert property (wrbuf_done && !other_cmd && !first_op
		|=> !interv)
		else $error("buffer write did not clear flag");

	cov_read_issued:   cover property (rd_start && !rd_media);
	cov_readback_full: cover property (send_end && !miscmp && (xfer_n > 24'h000004));
	cov_miscompare:    cover property (cmd_done && was_buf && (cmd_sense == 4'hE));
	cov_truncated:     cover property ((state == srbr_pkg::ST_EXEC) && buf_go &&
		(alloc_w[23:0] < total));

endmodule : srbr_core

// file: bench/srbr_far_model.sv
// Far-side model: diagnostic buffer memory and a stalling data-in sink
`timescale 1ns/100ps
module srbr_far_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Buffer read port, answered in the same cycle
	input  wire logic [17:0] buf_addr,
	output logic      [7:0]  buf_rdata,
	// Data-in sink
	input  wire logic        stall_en,
	output logic             din_ready
);
	// Contents follow the address, so every byte is known without a memory array
	assign buf_rdata = buf_addr[7:0] ^ buf_addr[15:8] ^ 8'h5A;
	// Random stalls stretch the data phase; off, the sink takes every byte
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			din_ready <= 1'b0;
		end else begin
			din_ready <= !stall_en || ($urandom_range(1, 0) == 1);
		end
	end
endmodule : srbr_far_model

// file: bench/tb_top.sv
// Self-checking testbench for the read and buffer readback interpreter
`timescale 1ns/100ps
`define CHK(nm, e, g) begin exp_v = (e); got_v = (g); checked++; if (got_v !== exp_v) begin \
	bad_count++; $display("wrong value %s expected %0h seen %0h", nm, exp_v, got_v); end end
module tb_top;
	// Design ports
	logic        clk, rst_b, cdb_valid, cdb_first, cmd_linked, other_cmd, wrbuf_done;
	logic        rd_start, rd_media, din_valid, din_ready, cmd_done, cmd_check, stall_en;
	logic        reg_wr, reg_rd, rd_d;
	logic [7:0]  cdb_byte, buf_rdata, din_byte;
	logic [31:0] rd_lba, reg_wdata, reg_rdata;
	logic [16:0] rd_count;
	logic [2:0]  rd_unit, unit;
	logic [17:0] buf_addr;
	logic [3:0]  cmd_sense, reg_addr;
	// Bench state and notes of expected results
	int          bad_count, checked, seed;
	logic [63:0] exp_v, got_v;
	logic [7:0]  cb [10];
	logic [52:0] q_rd [$];
	logic [4:0]  q_done [$];
	logic [7:0]  q_din [$];
	logic [31:0] q_reg [$];
	logic [31:0] last, avail;
	logic        cache, interv;
	// Oldest notes as the monitor takes them
	logic [52:0] n_rd;
	logic [7:0]  n_din;
	logic [4:0]  n_done;
	logic [31:0] n_reg;

	srbr_core i_srbr_core (
		.clk(clk), .rst_b(rst_b), .cdb_valid(cdb_valid), .cdb_first(cdb_first),
		.cdb_byte(cdb_byte), .cmd_linked(cmd_linked), .other_cmd(other_cmd),
		.wrbuf_done(wrbuf_done), .rd_start(rd_start), .rd_lba(rd_lba), .rd_count(rd_count),
		.rd_media(rd_media), .rd_unit(rd_unit), .buf_addr(buf_addr), .buf_rdata(buf_rdata),
		.din_valid(din_valid), .din_byte(din_byte), .din_ready(din_ready),
		.cmd_done(cmd_done), .cmd_check(cmd_check), .cmd_sense(cmd_sense),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);
	srbr_far_model i_srbr_far_model (
		.clk(clk), .rst_b(rst_b), .buf_addr(buf_addr), .buf_rdata(buf_rdata),
		.stall_en(stall_en), .din_ready(din_ready)
	);

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Monitor: each result takes the oldest note; an empty queue means unexpected
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rst_b) begin
			if (rd_start) begin
				n_rd = q_rd.size() ? q_rd.pop_front() : 'x;
				`CHK("read request", n_rd, {rd_lba, rd_count, rd_media, rd_unit})
			end
			if (din_valid && din_ready) begin
				n_din = q_din.size() ? q_din.pop_front() : 'x;
				`CHK("data byte", n_din, din_byte)
			end
			if (cmd_done) begin
				n_done = q_done.size() ? q_done.pop_front() : 'x;
				`CHK("status", n_done, {cmd_check, cmd_sense})
			end
			if (rd_d) begin
				n_reg = q_reg.size() ? q_reg.pop_front() : 'x;
				`CHK("register", n_reg, reg_rdata)
			end
		end
	end

	function automatic logic [7:0] buf_val(input int k);
		buf_val = k[7:0] ^ k[15:8] ^ 8'h5A;
	endfunction : buf_val

	// Print the counts and the verdict, then stop
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// Send n command bytes, then wait a bounded time for completion
	task automatic send_cmd(input int n);
		if (cb[0] != srbr_pkg::OP_RDBUF) interv = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			cdb_valid <= 1'b1;
			cdb_first <= (i == 0);
			cdb_byte  <= cb[i];
		end
		@(posedge clk);
		cdb_valid <= 1'b0;
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk);
			#1;
			if (cmd_done === 1'b1) begin
				`CHK("bytes missing", 0, q_din.size())
				return;
			end
		end
		bad_count++;
		complete_run();
	endtask : send_cmd

	// One-cycle register accesses
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
		q_reg.push_back(e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : reg_read

	// Pulse buffer-write completion (w=1) or another command (w=0)
	task automatic pulse(input logic w);
		@(posedge clk);
		wrbuf_done <= w;
		other_cmd  <= !w;
		@(posedge clk);
		wrbuf_done <= 1'b0;
		other_cmd  <= 1'b0;
		interv = !w;
	endtask : pulse

	// Short read; zero count stands for 256 blocks
	task automatic read6(input logic [20:0] a, input logic [7:0] c);
		logic [16:0] n;
		n = (c == 0) ? 17'h00100 : {9'h000, c};
		cb = '{srbr_pkg::OP_READ6, {unit, a[20:16]}, a[15:8], a[7:0], c, 0, 0, 0, 0, 0};
		q_rd.push_back({{11'h000, a}, n, !cache, unit});
		q_done.push_back(5'h00);
		last = a + n - 1;
		send_cmd(6);
	endtask : read6

	// Long read; page-out disable always sent clear
	task automatic read10(input logic [31:0] a, input logic [15:0] c, input logic f,
			input logic rel, input logic lk);
		logic [31:0] s;
		s = rel ? last + a : a;
		cb = '{srbr_pkg::OP_READ10, {unit, 1'b0, f, 2'b00, rel}, a[31:24], a[23:16],
			a[15:8], a[7:0], 0, c[15:8], c[7:0], 0};
		@(posedge clk);
		cmd_linked <= lk;
		if (rel && !lk) begin
			q_done.push_back({1'b1, srbr_pkg::SK_ILLEGAL});
		end else begin
			if (c != 0) begin
				q_rd.push_back({s, 1'b0, c, f | !cache, unit});
				last = s + c - 1;
			end
			q_done.push_back(5'h00);
		end
		send_cmd(10);
	endtask : read10

	// Buffer readback with the expected header and data noted
	task automatic rdbuf(input logic [2:0] m, input logic [23:0] al);
		int tot;
		cb = '{srbr_pkg::OP_RDBUF, {5'h00, m}, 0, 0, 0, 0, al[23:16], al[15:8], al[7:0], 0};
		if (m != srbr_pkg::MODE_DATA && m != srbr_pkg::MODE_HDR) begin
			q_done.push_back({1'b1, srbr_pkg::SK_ILLEGAL});
		end else begin
			tot = (m == srbr_pkg::MODE_DATA) ? avail + 4 : 4;
			for (int k = 0; k < tot && k < al; k++) begin
				q_din.push_back(k == 0 ? 8'h00 : k < 4 ? avail[8*(3-k) +: 8] : buf_val(k - 4));
			end
			q_done.push_back(interv ? {1'b1, srbr_pkg::SK_MISCOMPARE} : 5'h00);
		end
		send_cmd(10);
	endtask : rdbuf

	// Main sequence
	initial begin
		{cdb_valid, cdb_first, cdb_byte, cmd_linked, other_cmd, wrbuf_done} = '0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, stall_en, rst_b, unit, last} = '0;
		{bad_count, checked, avail} = '0;
		{cache, interv} = 2'b11;
		seed = $urandom(27);
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		reg_read(srbr_pkg::REG_STATUS, 32'h00000002);
		reg_read(srbr_pkg::REG_CTRL, 32'h00000001);
		reg_read(4'h2, 32'h00000000);
		reg_write(srbr_pkg::REG_AVAIL, 32'h0007FFFF);
		reg_read(srbr_pkg::REG_AVAIL, 32'h00040000);
		$display("test registers done");
		stall_en <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			unit = 3'($urandom());
			read6(21'($urandom()), (i == 0) ? 8'h00 : 8'($urandom()));
			read10($urandom(), (i == 0) ? 16'hFFFF : 16'($urandom_range(65535, 1)), i[0], 0, 0);
		end
		reg_write(srbr_pkg::REG_CTRL, 32'h00000000);
		cache = 1'b0;
		read10($urandom(), 16'h0001, 1'b0, 1'b0, 1'b0);
		reg_write(srbr_pkg::REG_CTRL, 32'h00000001);
		cache = 1'b1;
		read10($urandom(), 16'h0000, 1'b1, 1'b0, 1'b0);
		read10(32'hFFFFFFFB, 16'h0004, 1'b0, 1'b1, 1'b1);
		read10(32'h00000010, 16'h0002, 1'b0, 1'b1, 1'b1);
		read10(32'h00000003, 16'h0002, 1'b0, 1'b1, 1'b0);
		reg_read(srbr_pkg::REG_LAST_LBA, last);
		$display("test reads done");
		avail = 32'd10;
		reg_write(srbr_pkg::REG_AVAIL, avail);
		pulse(1'b1);
		reg_read(srbr_pkg::REG_STATUS, 32'h00000054);
		rdbuf(srbr_pkg::MODE_DATA, 24'h000006);
		rdbuf(srbr_pkg::MODE_HDR, 24'h0000FF);
		rdbuf(srbr_pkg::MODE_DATA, 24'h000000);
		rdbuf(srbr_pkg::MODE_DATA, 24'hFFFFFF);
		for (int m = 1; m < 8; m++) if (m != 3) rdbuf(3'(m), 24'h000100);
		reg_read(srbr_pkg::REG_AVAIL, avail);
		avail = 32'd0;
		reg_write(srbr_pkg::REG_AVAIL, avail);
		rdbuf(srbr_pkg::MODE_DATA, 24'h000032);
		avail = $urandom_range(300, 1);
		reg_write(srbr_pkg::REG_AVAIL, avail);
		pulse(1'b0);
		rdbuf(srbr_pkg::MODE_DATA, 24'h0000FF);
		$display("test buffer readback done");
		repeat (3) @(posedge clk);
		`CHK("notes left", 0, q_rd.size() + q_done.size() + q_din.size() + q_reg.size())
		complete_run();
	end
endmodule : tb_top
